// ### crl_top.sv
/*
 * Cable replacement link control: modem line mapping, receive break reset,
 * automatic connection with retry, RTS/CTS flow control and clock output.
 * Assumes AXI4-Lite software access, a link engine that reports up/fail,
 * and host pins synchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "crl_params.svh"
module crl_top (
	input  wire logic                  sys_clk,        // 200 MHz clock
	input  wire logic                  reset,          // Async reset, high
	input  wire logic [7:0]            s_axi_awaddr,   // Write address
	input  wire logic                  s_axi_awvalid,  // Write address valid
	output logic                       s_axi_awready,  // Write address ready
	input  wire logic [31:0]           s_axi_wdata,    // Write data
	input  wire logic [3:0]            s_axi_wstrb,    // Byte enables
	input  wire logic                  s_axi_wvalid,   // Write data valid
	output logic                       s_axi_wready,   // Write data ready
	output logic [1:0]                 s_axi_bresp,    // Write response
	output logic                       s_axi_bvalid,   // Write response valid
	input  wire logic                  s_axi_bready,   // Write response ready
	input  wire logic [7:0]            s_axi_araddr,   // Read address
	input  wire logic                  s_axi_arvalid,  // Read address valid
	output logic                       s_axi_arready,  // Read address ready
	output logic [31:0]                s_axi_rdata,    // Read data
	output logic [1:0]                 s_axi_rresp,    // Read response
	output logic                       s_axi_rvalid,   // Read data valid
	input  wire logic                  s_axi_rready,   // Read data ready
	input  wire logic                  host_rx,        // Host serial line
	input  wire logic                  dsr_n,          // DSR, low asserted
	input  wire logic                  cts_n,          // CTS, low asserted
	output logic                       rts_n,          // RTS, low asserted
	output logic [3:0]                 modem_line,     // Local modem outputs
	output logic                       carrier_n,      // DCD, low asserted
	output logic                       hw_reset_req,   // Break reset pulse
	input  wire crl_pkg::crl_modem_s   remote_modem,   // Bits from peer
	output crl_pkg::crl_modem_s        local_modem,    // Bits to peer
	output logic                       break_to_peer,  // Always low
	output crl_pkg::crl_link_req_s     link_req,       // Link engine request
	input  wire crl_pkg::crl_link_ack_s link_ack,      // Link engine answer
	input  wire logic [7:0]            rx_byte,        // Byte from peer
	input  wire logic                  rx_byte_valid,  // Byte strobe
	output logic                       rx_byte_ready,  // Buffer has room
	output logic [7:0]                 host_byte,      // Byte to host UART
	output logic                       host_byte_valid, // Byte ready
	input  wire logic                  host_byte_ready, // Host UART takes byte
	input  wire logic                  xtal_clk_en,    // 48 MHz crystal tick
	output logic [7:0]                 programmable_pin // Clock output pins
);
	import crl_pkg::*;

	localparam int MS_CYC  = `CRL_MS_CYCLES;
	localparam int BRK_CYC = `CRL_BREAK_CYCLES;

	// Software registers
	logic [31:0] ctrl;
	logic [31:0] map_a;
	logic [31:0] map_b;
	logic [31:0] map_c;
	logic [15:0] retry_ms;
	crl_modem_s  sw_modem;

	// Selects a bit of the remote status by a 2-bit code
	function automatic logic pick(input crl_modem_s m, input logic [1:0] sel);
		pick = m[sel];
	endfunction

	// Clamp a retry setting into its legal range
	function automatic logic [15:0] clamp_ms(input logic [15:0] v);
		if (v < `CRL_RETRY_MIN_MS) begin
			clamp_ms = `CRL_RETRY_MIN_MS;
		end else if (v > `CRL_RETRY_MAX_MS) begin
			clamp_ms = `CRL_RETRY_MAX_MS;
		end else begin
			clamp_ms = v;
		end
	endfunction

	// AXI write channel
	logic       aw_hold;
	logic       w_hold;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic       do_write;
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign do_write      = aw_hold && w_hold;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
			end
		end
	end

	// Byte lane merge
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
	                                      input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
		merge = old;
	endfunction

	logic wr_hit;
	always_comb begin
		unique case (aw_addr)
			`CRL_OFS_CTRL, `CRL_OFS_MAP_A, `CRL_OFS_MAP_B, `CRL_OFS_MAP_C,
			`CRL_OFS_RETRY, `CRL_OFS_MODEM: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Write response
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CRL_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `CRL_RESP_OKAY : `CRL_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register stores
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl     <= `CRL_CTRL_RESET;
			map_a    <= 32'h0000_0000;
			map_b    <= 32'h0000_0000;
			map_c    <= 32'h0000_0000;
			retry_ms <= `CRL_RETRY_DEF_MS;
			sw_modem <= '0;
		end else if (do_write) begin
			unique case (aw_addr)
				`CRL_OFS_CTRL:  ctrl  <= merge(ctrl, w_data, w_strb);
				`CRL_OFS_MAP_A: map_a <= merge(map_a, w_data, w_strb);
				`CRL_OFS_MAP_B: map_b <= merge(map_b, w_data, w_strb);
				`CRL_OFS_MAP_C: map_c <= merge(map_c, w_data, w_strb);
				`CRL_OFS_RETRY: retry_ms <= clamp_ms(16'(merge({16'h0000, retry_ms},
				                                     w_data, w_strb)));
				`CRL_OFS_MODEM: sw_modem <= w_data[3:0];
				default: ;
			endcase
		end
	end

	// Connection manager
	crl_state_e  state;
	logic [31:0] wait_cyc;
	logic [15:0] wait_ms;
	logic        dsr_on;
	logic        linked;
	assign dsr_on = !dsr_n;
	assign linked = (state == CRL_LINKED);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state    <= CRL_IDLE;
			wait_cyc <= 32'h0000_0000;
			wait_ms  <= 16'h0000;
		end else begin
			unique case (state)
				CRL_IDLE: begin
					if (ctrl[`CRL_CTRL_AUTO] && dsr_on) begin
						state <= ctrl[`CRL_CTRL_MASTER] ? CRL_CALL : CRL_LISTEN;
					end
				end
				CRL_LISTEN: begin
					if (!dsr_on && ctrl[`CRL_CTRL_DSRDROP]) begin
						state <= CRL_COMMAND;
					end else if (link_ack.up) begin
						state <= CRL_LINKED;
					end
				end
				CRL_CALL: begin
					if (!dsr_on && ctrl[`CRL_CTRL_DSRDROP]) begin
						state <= CRL_COMMAND;
					end else if (link_ack.up) begin
						state <= CRL_LINKED;
					end else if (link_ack.fail) begin
						state    <= CRL_WAIT;
						wait_cyc <= 32'h0000_0000;
						wait_ms  <= 16'h0000;
					end
				end
				CRL_WAIT: begin
					if (wait_cyc == 32'(MS_CYC - 1)) begin
						wait_cyc <= 32'h0000_0000;
						wait_ms  <= wait_ms + 16'h0001;
						if (wait_ms + 16'h0001 >= retry_ms) begin
							state <= CRL_CALL;
						end
					end else begin
						wait_cyc <= wait_cyc + 32'h0000_0001;
					end
				end
				CRL_LINKED: begin
					if (!dsr_on && ctrl[`CRL_CTRL_DSRDROP]) begin
						state <= CRL_COMMAND;
					end else if (!link_ack.up) begin
						state <= CRL_IDLE;
					end
				end
				CRL_COMMAND: begin
					if (dsr_on) begin
						state <= CRL_IDLE;
					end
				end
				default: state <= CRL_IDLE;
			endcase
		end
	end

	// Link requests: master hidden, slave visibility from startup code
	always_comb begin
		link_req.call    = (state == CRL_CALL);
		link_req.listen  = (state == CRL_LISTEN);
		link_req.visible = !ctrl[`CRL_CTRL_MASTER] &&
		                   (ctrl[`CRL_CTRL_STARTUP] == `CRL_STARTUP_VISIBLE);
		link_req.filter  = ctrl[`CRL_CTRL_ADDRSET];
	end

	// Outgoing modem bits; break never forwarded
	assign break_to_peer = 1'b0;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			local_modem <= '0;
		end else begin
			local_modem.dtr_bit <= sw_modem.dtr_bit | dsr_on;
			local_modem.rts_bit <= sw_modem.rts_bit | !cts_n;
			local_modem.carrier <= sw_modem.carrier | linked;
			local_modem.ring    <= sw_modem.ring;
		end
	end

	// Remote bits routed to local lines: map_a selects, map_b enables,
	// map_c inverts
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			modem_line <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				modem_line[i] <= map_b[i] &
				                 (pick(remote_modem, map_a[i*2 +: 2]) ^ map_c[i]);
			end
		end
	end

	// Carrier detect follows the link
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			carrier_n <= 1'b1;
		end else begin
			carrier_n <= !linked;
		end
	end

	// Break detector: low time counter clears on any high sample
	logic [31:0] brk_cnt;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			brk_cnt      <= 32'h0000_0000;
			hw_reset_req <= 1'b0;
		end else begin
			hw_reset_req <= 1'b0;
			if (host_rx) begin
				brk_cnt <= 32'h0000_0000;
			end else if (brk_cnt <= 32'(BRK_CYC)) begin
				brk_cnt <= brk_cnt + 32'h0000_0001;
				hw_reset_req <= (brk_cnt == 32'(BRK_CYC));
			end
		end
	end

	// Receive buffer towards the host; RTS from its fill state
	logic fifo_in_ready;
	crl_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_data   (rx_byte),
		.in_valid  (rx_byte_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (host_byte),
		.out_valid (host_byte_valid),
		.out_ready (host_byte_ready && !cts_n)
	);
	assign rx_byte_ready = fifo_in_ready;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rts_n <= 1'b1;
		end else begin
			rts_n <= !fifo_in_ready;
		end
	end

	// Crystal divider: period of 6, 3, 2 or 1 ticks of the 48 MHz crystal
	logic [2:0] div_cnt;
	logic       clk_out;
	logic [2:0] half;
	always_comb begin
		unique case (ctrl[`CRL_CTRL_CLKSEL])
			2'b00: half = 3'h5;   // 8 MHz
			2'b01: half = 3'h2;   // 16 MHz, uneven duty
			2'b10: half = 3'h1;   // 24 MHz
			2'b11: half = 3'h0;   // 48 MHz, the tick itself
		endcase
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			div_cnt <= 3'h0;
		end else if (xtal_clk_en) begin
			div_cnt <= (div_cnt >= half) ? 3'h0 : div_cnt + 3'h1;
		end
	end
	// High for the first half of each period at 8 and 24 MHz; first two of three ticks at 16 MHz; the tick pulse itself at 48 MHz
	assign clk_out = (half == 3'h0) ? xtal_clk_en : (div_cnt <= {1'b0, half[2:1]});
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			programmable_pin <= 8'h00;
		end else begin
			programmable_pin <= 8'h00;
			programmable_pin[ctrl[`CRL_CTRL_PINSEL]] <= ctrl[`CRL_CTRL_CLKEN] & clk_out;
		end
	end

	// AXI read channel
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `CRL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `CRL_RESP_OKAY;
			unique case (s_axi_araddr)
				`CRL_OFS_CTRL:   s_axi_rdata <= ctrl;
				`CRL_OFS_MAP_A:  s_axi_rdata <= map_a;
				`CRL_OFS_MAP_B:  s_axi_rdata <= map_b;
				`CRL_OFS_MAP_C:  s_axi_rdata <= map_c;
				`CRL_OFS_RETRY:  s_axi_rdata <= {16'h0000, retry_ms};
				`CRL_OFS_STATUS: s_axi_rdata <= {21'h00000, remote_modem, !rts_n, dsr_on,
				                                 linked, 1'b0, state};
				`CRL_OFS_MODEM:  s_axi_rdata <= {28'h0000000, sw_modem};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `CRL_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;
endmodule

// ### crl_params.svh
/*
 * Constants for the cable replacement link control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 200 MHz system clock and inclusion by bare name.
 */
`ifndef CRL_PARAMS_SVH
`define CRL_PARAMS_SVH

// Register byte offsets
`define CRL_OFS_CTRL     8'h00
`define CRL_OFS_MAP_A    8'h04
`define CRL_OFS_MAP_B    8'h08
`define CRL_OFS_MAP_C    8'h0C
`define CRL_OFS_RETRY    8'h10
`define CRL_OFS_STATUS   8'h14
`define CRL_OFS_MODEM    8'h18
`define CRL_OFS_TXDATA   8'h1C
`define CRL_OFS_RXDATA   8'h20

// Control register fields
`define CRL_CTRL_AUTO    0
`define CRL_CTRL_MASTER  1
`define CRL_CTRL_DSRDROP 2
`define CRL_CTRL_ADDRSET 3
`define CRL_CTRL_STARTUP 7:4
`define CRL_CTRL_CLKSEL  9:8
`define CRL_CTRL_PINSEL  12:10
`define CRL_CTRL_CLKEN   13
`define CRL_CTRL_RESET   32'h0000_0007

// Startup visibility codes
`define CRL_STARTUP_HIDDEN 4'h3
`define CRL_STARTUP_VISIBLE 4'h4

// Retry delay in ms
`define CRL_RETRY_DEF_MS 16'd2000
`define CRL_RETRY_MIN_MS 16'd100
`define CRL_RETRY_MAX_MS 16'd15000

// Timing
`define CRL_CLK_MHZ      200
`define CRL_MS_CYCLES    (`CRL_CLK_MHZ * 1000)
`define CRL_BREAK_MS     100
`define CRL_BREAK_CYCLES (`CRL_BREAK_MS * `CRL_MS_CYCLES)

// Access answers: OKAY, or SLVERR for unmapped offsets
`define CRL_RESP_OKAY    2'b00
`define CRL_RESP_SLVERR  2'b10
`endif

// ### crl_pkg.sv
/*
 * Types shared by the cable replacement link control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package crl_pkg;
	// Connection manager states
	typedef enum logic [2:0] {
		CRL_IDLE    = 3'b000,
		CRL_LISTEN  = 3'b001,
		CRL_CALL    = 3'b010,
		CRL_WAIT    = 3'b011,
		CRL_LINKED  = 3'b100,
		CRL_COMMAND = 3'b101
	} crl_state_e;

	// Four modem status bits carried in the link message
	typedef struct packed {
		logic ring;
		logic carrier;
		logic rts_bit;
		logic dtr_bit;
	} crl_modem_s;

	// Link side request and answer
	typedef struct packed {
		logic call;
		logic listen;
		logic visible;
		logic filter;
	} crl_link_req_s;

	typedef struct packed {
		logic up;
		logic fail;
	} crl_link_ack_s;
endpackage

// ### crl_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active high reset.
 */
`timescale 1ns/1ps
module crl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk,   // System clock
	input  wire logic             reset,     // Async reset
	input  wire logic [WIDTH-1:0] in_data,   // Fill data
	input  wire logic             in_valid,  // Fill valid
	output logic                  in_ready,  // Not full
	output logic [WIDTH-1:0]      out_data,  // Head word
	output logic                  out_valid, // Not empty
	input  wire logic             out_ready  // Drain ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// Handshakes
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	// Storage
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// ### crl_top_assertions.sv
/* Port checker for crl_top: break reset, buffer flow control, link and modem lines.
   Assumes one clock domain and the fixed 200 MHz break threshold. */
`timescale 1ns/1ps
module crl_top_assertions (
	input wire logic                  sys_clk,         // Clock
	input wire logic                  reset,           // Async reset
	input wire logic                  host_rx,         // Host serial line
	input wire logic                  dsr_n,           // DSR
	input wire logic                  cts_n,           // CTS
	input wire logic                  rts_n,           // RTS
	input wire logic                  carrier_n,       // Carrier detect
	input wire logic                  hw_reset_req,    // Break reset pulse
	input wire crl_pkg::crl_modem_s   local_modem,     // Bits to peer
	input wire logic                  break_to_peer,   // Break forward
	input wire crl_pkg::crl_link_req_s link_req,       // Link request
	input wire crl_pkg::crl_link_ack_s link_ack,       // Link answer
	input wire logic                  rx_byte_ready,   // Buffer room
	input wire logic [7:0]            host_byte,       // Head byte
	input wire logic                  host_byte_valid, // Head valid
	input wire logic                  host_byte_ready  // Host takes byte
);
	import crl_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	localparam logic [24:0] BREAK_LO = 25'h1312CFE;
	localparam logic [24:0] BREAK_HI = 25'h1312D01;
	logic [24:0] low_cnt;

	// Continuous low time on the host line, saturating
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			low_cnt <= 25'h0;
		else if (host_rx)
			low_cnt <= 25'h0;
		else if (low_cnt != 25'h1FFFFFF)
			low_cnt <= low_cnt + 25'h1;
	end

	property p_break_reset;
		hw_reset_req |-> low_cnt >= BREAK_LO && low_cnt <= BREAK_HI;
	endproperty
	a_break_reset: assert property (p_break_reset)
		else $error("reset request away from break threshold");
	property p_pulse_one;
		hw_reset_req |=> !hw_reset_req;
	endproperty
	a_pulse_one: assert property (p_pulse_one)
		else $error("reset request longer than one cycle");
	property p_no_break_fwd;
		!break_to_peer;
	endproperty
	a_no_break_fwd: assert property (p_no_break_fwd)
		else $error("break forwarded to peer");
	property p_carrier_up;
		!carrier_n |-> $past(link_ack.up) || $past(link_ack.up, 2);
	endproperty
	a_carrier_up: assert property (p_carrier_up)
		else $error("carrier asserted without link");
	property p_rts_full;
		!rx_byte_ready |=> rts_n;
	endproperty
	a_rts_full: assert property (p_rts_full)
		else $error("rts asserted while buffer full");
	property p_rts_room;
		rx_byte_ready |=> !rts_n;
	endproperty
	a_rts_room: assert property (p_rts_room)
		else $error("rts withdrawn while buffer has room");
	property p_hold_head;
		host_byte_valid && (cts_n || !host_byte_ready) |=> host_byte_valid && $stable(host_byte);
	endproperty
	a_hold_head: assert property (p_hold_head)
		else $error("head byte lost while host not ready");
	property p_fail_wait;
		link_ack.fail && link_req.call |=> (!link_req.call) [*8];
	endproperty
	a_fail_wait: assert property (p_fail_wait)
		else $error("call retried without delay");
	property p_dtr_follow;
		!dsr_n |=> local_modem.dtr_bit;
	endproperty
	a_dtr_follow: assert property (p_dtr_follow)
		else $error("dtr bit not set while dsr low");
endmodule

bind crl_top crl_top_assertions crl_top_assertions_i (
	.sys_clk, .reset, .host_rx, .dsr_n, .cts_n, .rts_n, .carrier_n, .hw_reset_req,
	.local_modem, .break_to_peer, .link_req, .link_ack, .rx_byte_ready,
	.host_byte, .host_byte_valid, .host_byte_ready
);

// ### crl_host_model.sv
/* Host UART model: loops its DTR onto the device DSR, drives CTS and the serial line,
   and keeps the last four bytes it took. Assumes the clock of the block. */
`timescale 1ns/1ps
module crl_host_model (
	input  wire logic        sys_clk,         // Clock
	input  wire logic        reset,           // Async reset
	input  wire logic        dtr_on,          // Host DTR asserted
	input  wire logic        stall,           // Host cannot take bytes
	input  wire logic        brk,             // Hold line in break
	input  wire logic [7:0]  host_byte,       // Byte offered
	input  wire logic        host_byte_valid, // Byte valid
	output logic             host_rx,         // Serial line
	output logic             dsr_n,           // Device DSR
	output logic             cts_n,           // Device CTS
	output logic             host_byte_ready, // UART takes byte
	output logic [31:0]      got              // Last four bytes
);
	// DTR tied to the device DSR, low when asserted
	assign dsr_n = !dtr_on;
	// CTS low only while the host can take bytes
	assign cts_n = stall;
	assign host_byte_ready = 1'b1;
	// Line idles high and carries no data, so RTS is never overrun
	assign host_rx = !brk;
	// Keep each byte taken while CTS is asserted
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			got <= 32'h0;
		else if (host_byte_valid && !cts_n)
			got <= {got[23:0], host_byte};
	end
endmodule

// ### crl_top_tb.sv
/* Self-checking bench for crl_top: registers, modem mapping, link control,
   receive buffer and clock output. Assumes checker and host model compiled first. */
`timescale 1ns/1ps
`include "crl_params.svh"
`define CHK(NM, E, S) begin checks_done++; if ((S) !== (E)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", NM, E, S); end end
`define WAITC(C) begin int k; k = 0; while (!(C) && k < 5000) begin \
	@(posedge sys_clk); k++; end if (!(C)) timeout_end(); end
module crl_top_tb;
	import crl_pkg::*;
	logic          sys_clk = 1'b0, reset = 1'b1, ok;
	logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_byte = 8'h00;
	logic [31:0]   s_axi_wdata = 32'h0;
	logic [3:0]    s_axi_wstrb = 4'hF;
	logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_byte_valid = 1'b0;
	logic          xtal_clk_en = 1'b0, dtr_on = 1'b0, stall = 1'b1, brk = 1'b0;
	logic [1:0]    xt = 2'h0, s_axi_bresp, s_axi_rresp, resp;
	crl_modem_s    remote_modem = 4'h0, local_modem;
	crl_link_ack_s link_ack = 2'h0;
	crl_link_req_s link_req;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic          rts_n, carrier_n, hw_reset_req, break_to_peer, rx_byte_ready;
	logic          host_byte_valid, host_byte_ready, host_rx, dsr_n, cts_n;
	logic [31:0]   s_axi_rdata, host_got;
	logic [3:0]    modem_line;
	logic [7:0]    host_byte, programmable_pin, pins_seen;
	logic [31:0]   rt_in[4] = '{32'h32, 32'h64, 32'h3A98, 32'h4E20};
	logic [31:0]   rt_exp[4] = '{32'h64, 32'h64, 32'h3A98, 32'h3A98};
	logic [23:0]   mtab[4] = '{24'hE4F0AA, 24'hE4FFA5, 24'h005015, 24'h1BF21A};
	int            n_errors = 0, checks_done = 0;

	crl_top crl_top_i (
		.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_rx, .dsr_n, .cts_n, .rts_n,
		.modem_line, .carrier_n, .hw_reset_req, .remote_modem, .local_modem,
		.break_to_peer, .link_req, .link_ack, .rx_byte, .rx_byte_valid, .rx_byte_ready,
		.host_byte, .host_byte_valid, .host_byte_ready, .xtal_clk_en, .programmable_pin
	);
	crl_host_model crl_host_model_i (
		.sys_clk, .reset, .dtr_on, .stall, .brk, .host_byte, .host_byte_valid,
		.host_rx, .dsr_n, .cts_n, .host_byte_ready, .got(host_got)
	);

	// 200 MHz clock and a crystal tick every fourth cycle
	always #2.5 sys_clk = !sys_clk;
	always @(posedge sys_clk) begin
		xt <= xt + 2'h1;
		xtal_clk_en <= (xt == 2'h3);
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic timeout_end();
		n_errors++;
		complete_run();
	endtask
	// Write one word; address and data released as each is taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 200) timeout_end();
	endtask
	// Read one word and compare data and response
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
			input string nm);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 200) timeout_end();
		`CHK(nm, e, s_axi_rdata)
		`CHK(nm, er, s_axi_rresp)
	endtask
	// Offer one byte from the peer; valid stays up for the next caller
	task automatic push(input logic [7:0] b, output logic taken);
		int n;
		rx_byte <= b;
		rx_byte_valid <= 1'b1;
		taken = 1'b0;
		for (n = 0; n < 20 && !taken; n++) begin
			@(posedge sys_clk);
			taken = rx_byte_ready;
		end
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		rd_chk(`CRL_OFS_CTRL, 32'h7, `CRL_RESP_OKAY, "ctrl");
		rd_chk(`CRL_OFS_RETRY, 32'h7D0, `CRL_RESP_OKAY, "retry");
		rd_chk(`CRL_OFS_TXDATA, 32'h0, `CRL_RESP_SLVERR, "unmapped");
		axi_wr(`CRL_OFS_RXDATA, 32'h1, resp);
		`CHK("unmapped write", `CRL_RESP_SLVERR, resp)
		`CHK("no call without dsr", 1'b0, link_req.call)
		foreach (rt_in[i]) begin
			axi_wr(`CRL_OFS_RETRY, rt_in[i], resp);
			rd_chk(`CRL_OFS_RETRY, rt_exp[i], `CRL_RESP_OKAY, "retry clamp");
		end
		// Route remote bits through select, enable and invert
		foreach (mtab[i]) begin
			axi_wr(`CRL_OFS_MAP_A, {24'h0, mtab[i][23:16]}, resp);
			axi_wr(`CRL_OFS_MAP_B, {28'h0, mtab[i][15:12]}, resp);
			axi_wr(`CRL_OFS_MAP_C, {28'h0, mtab[i][11:8]}, resp);
			remote_modem <= mtab[i][7:4];
			repeat (3) @(posedge sys_clk);
			`CHK("modem line", mtab[i][3:0], modem_line)
		end
		axi_wr(`CRL_OFS_MODEM, 32'h8, resp);
		repeat (2) @(posedge sys_clk);
		`CHK("ring bit", 1'b1, local_modem.ring)
		brk <= 1'b1;
		repeat (1000) @(posedge sys_clk);
		brk <= 1'b0;
		`CHK("no break sent", 1'b0, break_to_peer)
		`CHK("short break", 1'b0, hw_reset_req)
		// Slave role waits for a peer once DSR is asserted
		axi_wr(`CRL_OFS_CTRL, 32'h45, resp);
		dtr_on <= 1'b1;
		`WAITC(link_req.listen)
		`CHK("slave call", 1'b0, link_req.call)
		`CHK("visible", 1'b1, link_req.visible)
		`CHK("any peer", 1'b0, link_req.filter)
		`CHK("dtr bit", 1'b1, local_modem.dtr_bit)
		axi_wr(`CRL_OFS_CTRL, 32'h3D, resp);
		repeat (2) @(posedge sys_clk);
		`CHK("hidden", 1'b0, link_req.visible)
		`CHK("one peer", 1'b1, link_req.filter)
		link_ack <= 2'h2;
		`WAITC(!carrier_n)
		`CHK("carrier bit", 1'b1, local_modem.carrier)
		dtr_on <= 1'b0;
		`WAITC(carrier_n)
		link_ack <= 2'h0;
		// Master role calls, calls again after loss and backs off on failure
		axi_wr(`CRL_OFS_CTRL, 32'h7, resp);
		dtr_on <= 1'b1;
		`WAITC(link_req.call)
		`CHK("master hidden", 1'b0, link_req.visible)
		link_ack <= 2'h2;
		`WAITC(!carrier_n)
		link_ack <= 2'h0;
		`WAITC(link_req.call)
		link_ack <= 2'h1;
		@(posedge sys_clk);
		link_ack <= 2'h0;
		repeat (2) @(posedge sys_clk);
		`CHK("retry wait", 1'b0, link_req.call)
		// Fill the buffer while the host holds CTS off, then drain it
		@(posedge sys_clk);
		for (int i = 0; i < 5; i++) begin
			push(8'hA0 + i[7:0], ok);
			`CHK("byte taken", (i < 4), ok)
		end
		`CHK("rts when full", 1'b1, rts_n)
		`CHK("rts bit off", 1'b0, local_modem.rts_bit)
		stall <= 1'b0;
		push(8'hA4, ok);
		`CHK("late byte", 1'b1, ok)
		`CHK("rts bit", 1'b1, local_modem.rts_bit)
		rx_byte_valid <= 1'b0;
		`WAITC(!host_byte_valid)
		`CHK("byte order", 32'hA1A2A3A4, host_got)
		// Every divider setting drives only the selected pin
		for (int s = 0; s < 4; s++) begin
			axi_wr(`CRL_OFS_CTRL, 32'h2807 | (s << 8), resp);
			pins_seen = 8'h00;
			repeat (200) begin
				@(posedge sys_clk);
				pins_seen = pins_seen | programmable_pin;
			end
			`CHK("clock pin", 8'h04, pins_seen)
		end
		complete_run();
	end
endmodule
